// ---- pkg/arce_consts.svh ----
/*
 * Offsets, field positions, codes and geometry for the read command engine.
 * Assumes a 32-bit APB slave where each register takes one word (index times four).
 */
`ifndef ARCE_CONSTS_SVH
`define ARCE_CONSTS_SVH

// Register indices; byte address is index times four
`define ARCE_IDX_DATA     4'h0
`define ARCE_IDX_FEATURE  4'h1
`define ARCE_IDX_COUNT    4'h2
`define ARCE_IDX_SECTOR   4'h3
`define ARCE_IDX_TRK_LO   4'h4
`define ARCE_IDX_TRK_HI   4'h5
`define ARCE_IDX_UNIT     4'h6
`define ARCE_IDX_OPCODE   4'h7
`define ARCE_IDX_MULT     4'h8

// Opcodes
`define ARCE_OP_MULTI     8'hC4
`define ARCE_OP_READ0     8'h20
`define ARCE_OP_READ1     8'h21
`define ARCE_OP_VERIFY0   8'h40
`define ARCE_OP_VERIFY1   8'h41
`define ARCE_OP_RECAL_HI  4'h1

// Status, error and unit bits
`define ARCE_ST_BSY       7
`define ARCE_ST_RDY       6
`define ARCE_ST_DSC       4
`define ARCE_ST_DRQ       3
`define ARCE_ST_CORR      2
`define ARCE_ST_ERR       0
`define ARCE_ER_UNC       6
`define ARCE_ER_ABRT      2
`define ARCE_UNIT_LBA     2

// Media answer codes
`define ARCE_MED_OK       2'h0
`define ARCE_MED_CORR     2'h1
`define ARCE_MED_HARD     2'h2

// Sector and block sizes
`define ARCE_SECT_LAST    8'hFF
`define ARCE_MULT_MAX     3'h4
`define ARCE_COUNT_FULL   9'h100

// Plain default geometry for address stepping in track form
`define ARCE_CHS_SPT      8'h20
`define ARCE_CHS_MAXHEAD  4'hF

`endif

// ---- pkg/arce_pkg.sv ----
/*
 * Types of the read command engine: state encodings and the register struct.
 * Assumes arce_consts.svh for all numeric constants.
 */
package arce_pkg;

    typedef enum logic [2:0] {
        ARCE_IDLE   = 3'b000,
        ARCE_LOAD   = 3'b001,
        ARCE_FETCH  = 3'b010,
        ARCE_XFER   = 3'b011,
        ARCE_FINISH = 3'b100
    } arce_state_e;

    typedef enum logic [1:0] {
        ARCE_K_READ   = 2'b00,
        ARCE_K_MULTI  = 2'b01,
        ARCE_K_VERIFY = 2'b10
    } arce_kind_e;

    typedef struct packed {
        arce_state_e st;
        arce_kind_e  kind;
        logic [7:0]  feat;
        logic [7:0]  cnt;
        logic [3:0]  unit_hi;
        logic [27:0] ta;
        logic [27:0] fa;
        logic [2:0]  mult;
        logic [7:0]  err;
        logic        bsy;
        logic        drq;
        logic        corr;
        logic        errb;
        logic        intrq;
        logic [8:0]  rem;
        logic [2:0]  blk_n;
        logic [2:0]  sidx;
        logic [7:0]  wcnt;
        logic [9:0]  rptr;
        logic        hard;
        logic        hold;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        med_req;
        logic        med_verify;
    } arce_state_s;

endpackage : arce_pkg

// ---- core/arce_sector_buf.sv ----
/*
 * Sector buffer: four sectors of 256 half-words, one write port, one read port.
 * Assumes the engine never reads a word in the cycle it is written.
 */
`timescale 1ns/1ps

module arce_sector_buf (
    input  wire logic        sys_clk,
    input  wire logic        we,
    input  wire logic [9:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [9:0]  raddr,
    output logic      [15:0] rdata
);

    logic [15:0] mem [0:1023];

    // No reset: contents only matter after a media fill
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read is combinational so the bus can answer without wait states
    assign rdata = mem[raddr];

endmodule : arce_sector_buf

// ---- core/arce_engine.sv ----
/*
 * Read-family command engine behind an APB task-file: block, single, verify, no-op.
 * Assumes a media engine that fills sectors word by word and reports a status.
 */
`timescale 1ns/1ps
`include "arce_consts.svh"

module arce_engine
    import arce_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             intrq,
    output logic             med_req,
    output logic      [27:0] med_addr,
    output logic             med_lba,
    output logic             med_verify,
    input  wire logic        med_wvalid,
    input  wire logic [15:0] med_wdata,
    input  wire logic        med_done,
    input  wire logic [1:0]  med_status
);

    arce_state_s st_r;
    arce_state_s st_nxt;
    logic [15:0] buf_rdata;
    logic [3:0]  idx;
    logic        mapped;
    logic        setup;
    logic        done_acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        buf_we;
    logic [9:0]  buf_waddr;
    logic [7:0]  status;
    logic        is_lba;

    assign idx      = paddr[5:2];
    assign mapped   = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (idx <= `ARCE_IDX_MULT);
    assign setup    = psel && !penable;
    assign done_acc = psel && penable && st_r.pready;
    assign wr_acc   = done_acc && pwrite && mapped;
    assign rd_acc   = done_acc && !pwrite && mapped;
    assign is_lba   = st_r.unit_hi[`ARCE_UNIT_LBA];
    assign buf_we   = (st_r.st == ARCE_FETCH) && med_wvalid && !st_r.med_verify;
    assign buf_waddr = {st_r.sidx[1:0], st_r.wcnt};

    always_comb begin
        status = 8'h00;
        status[`ARCE_ST_BSY]  = st_r.bsy;
        status[`ARCE_ST_RDY]  = !st_r.bsy;
        status[`ARCE_ST_DSC]  = 1'b1;
        status[`ARCE_ST_DRQ]  = st_r.drq;
        status[`ARCE_ST_CORR] = st_r.corr;
        status[`ARCE_ST_ERR]  = st_r.errb;
    end

    // Next sector: plain increment in linear form, sector/head/track roll otherwise
    function automatic logic [27:0] arce_step(input logic [27:0] a, input logic lba);
        logic [27:0] r;
        r = a;
        if (lba) begin
            r = a + 28'h0000001;
        end else if (a[7:0] >= `ARCE_CHS_SPT) begin
            r[7:0] = 8'h01;
            if (a[27:24] == `ARCE_CHS_MAXHEAD) begin
                r[27:24] = 4'h0;
                r[23:8]  = a[23:8] + 16'h0001;
            end else begin
                r[27:24] = a[27:24] + 4'h1;
            end
        end else begin
            r[7:0] = a[7:0] + 8'h01;
        end
        return r;
    endfunction : arce_step

    always_comb begin
        st_nxt = st_r;

        // Bus answer: zero wait states, read data captured in the setup cycle
        st_nxt.pready  = setup;
        st_nxt.pslverr = setup && !mapped;
        if (setup) begin
            st_nxt.prdata = 32'h00000000;
            case (idx)
                `ARCE_IDX_DATA:    st_nxt.prdata = (st_r.st == ARCE_XFER) ? {16'h0000, buf_rdata} : 32'h00000000;
                `ARCE_IDX_FEATURE: st_nxt.prdata = {24'h000000, st_r.err};
                `ARCE_IDX_COUNT:   st_nxt.prdata = {24'h000000, st_r.cnt};
                `ARCE_IDX_SECTOR:  st_nxt.prdata = {24'h000000, st_r.ta[7:0]};
                `ARCE_IDX_TRK_LO:  st_nxt.prdata = {24'h000000, st_r.ta[15:8]};
                `ARCE_IDX_TRK_HI:  st_nxt.prdata = {24'h000000, st_r.ta[23:16]};
                `ARCE_IDX_UNIT:    st_nxt.prdata = {24'h000000, st_r.unit_hi, st_r.ta[27:24]};
                `ARCE_IDX_OPCODE:  st_nxt.prdata = {24'h000000, status};
                `ARCE_IDX_MULT:    st_nxt.prdata = {29'h00000000, st_r.mult};
                default:           st_nxt.prdata = 32'h00000000;
            endcase
        end

        // Status read acknowledges the interrupt
        if (rd_acc && idx == `ARCE_IDX_OPCODE) begin
            st_nxt.intrq = 1'b0;
        end

        // Task registers are writable only while the engine is idle
        if (wr_acc && st_r.st == ARCE_IDLE) begin
            case (idx)
                `ARCE_IDX_FEATURE: st_nxt.feat = pwdata[7:0];
                `ARCE_IDX_COUNT:   st_nxt.cnt = pwdata[7:0];
                `ARCE_IDX_SECTOR:  st_nxt.ta[7:0] = pwdata[7:0];
                `ARCE_IDX_TRK_LO:  st_nxt.ta[15:8] = pwdata[7:0];
                `ARCE_IDX_TRK_HI:  st_nxt.ta[23:16] = pwdata[7:0];
                `ARCE_IDX_UNIT: begin
                    st_nxt.unit_hi = pwdata[7:4];
                    st_nxt.ta[27:24] = pwdata[3:0];
                end
                `ARCE_IDX_MULT: begin
                    // Sizes 1, 2 and 4 only; anything else disables block reads
                    if (pwdata[2:0] == 3'h1 || pwdata[2:0] == 3'h2 || pwdata[2:0] == `ARCE_MULT_MAX) begin
                        st_nxt.mult = pwdata[2:0];
                    end else begin
                        st_nxt.mult = 3'h0;
                    end
                end
                `ARCE_IDX_OPCODE: begin
                    st_nxt.intrq = 1'b0;
                    st_nxt.err   = 8'h00;
                    st_nxt.errb  = 1'b0;
                    st_nxt.corr  = 1'b0;
                    st_nxt.hard  = 1'b0;
                    st_nxt.hold  = 1'b0;
                    st_nxt.fa    = st_r.ta;
                    st_nxt.rem   = (st_r.cnt == 8'h00) ? `ARCE_COUNT_FULL : {1'b0, st_r.cnt};
                    if (pwdata[7:4] == `ARCE_OP_RECAL_HI) begin
                        st_nxt.bsy = 1'b1;
                        st_nxt.st  = ARCE_FINISH;
                    end else if (pwdata[7:0] == `ARCE_OP_MULTI) begin
                        st_nxt.kind = ARCE_K_MULTI;
                        if (st_r.mult == 3'h0) begin
                            st_nxt.errb = 1'b1;
                            st_nxt.err[`ARCE_ER_ABRT] = 1'b1;
                            st_nxt.intrq = 1'b1;
                        end else begin
                            st_nxt.bsy = 1'b1;
                            st_nxt.st  = ARCE_LOAD;
                        end
                    end else if (pwdata[7:0] == `ARCE_OP_READ0 || pwdata[7:0] == `ARCE_OP_READ1) begin
                        st_nxt.kind = ARCE_K_READ;
                        st_nxt.bsy  = 1'b1;
                        st_nxt.st   = ARCE_LOAD;
                    end else if (pwdata[7:0] == `ARCE_OP_VERIFY0 || pwdata[7:0] == `ARCE_OP_VERIFY1) begin
                        st_nxt.kind = ARCE_K_VERIFY;
                        st_nxt.bsy  = 1'b1;
                        st_nxt.st   = ARCE_LOAD;
                    end else begin
                        // Opcodes outside this engine are refused outright
                        st_nxt.errb = 1'b1;
                        st_nxt.err[`ARCE_ER_ABRT] = 1'b1;
                        st_nxt.intrq = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        case (st_r.st)
            ARCE_IDLE: begin
            end
            ARCE_FINISH: begin
                st_nxt.bsy   = 1'b0;
                st_nxt.intrq = 1'b1;
                st_nxt.st    = ARCE_IDLE;
            end
            ARCE_LOAD: begin
                // Block length: one sector, or the smaller of block size and what is left
                if (st_r.kind == ARCE_K_MULTI && st_r.rem >= {6'h00, st_r.mult}) begin
                    st_nxt.blk_n = st_r.mult;
                end else if (st_r.kind == ARCE_K_MULTI) begin
                    st_nxt.blk_n = st_r.rem[2:0];
                end else begin
                    st_nxt.blk_n = 3'h1;
                end
                st_nxt.sidx       = 3'h0;
                st_nxt.wcnt       = 8'h00;
                st_nxt.med_req    = 1'b1;
                st_nxt.med_verify = (st_r.kind == ARCE_K_VERIFY);
                st_nxt.st         = ARCE_FETCH;
            end
            ARCE_FETCH: begin
                if (buf_we) begin
                    st_nxt.wcnt = st_r.wcnt + 8'h01;
                end
                if (med_done) begin
                    st_nxt.med_req = 1'b0;
                    st_nxt.wcnt    = 8'h00;
                    st_nxt.rem     = st_r.rem - 9'h001;
                    if (!st_r.hold) begin
                        st_nxt.ta = st_r.fa;
                    end
                    if (med_status == `ARCE_MED_CORR) begin
                        st_nxt.corr = 1'b1;
                    end
                    if (med_status == `ARCE_MED_HARD) begin
                        // Address freezes on the first failing sector
                        st_nxt.hard = 1'b1;
                        st_nxt.hold = 1'b1;
                        st_nxt.errb = 1'b1;
                        st_nxt.err[`ARCE_ER_UNC] = 1'b1;
                    end
                    if (st_r.kind == ARCE_K_VERIFY) begin
                        if (med_status == `ARCE_MED_HARD) begin
                            st_nxt.cnt   = st_r.rem[7:0];
                            st_nxt.bsy   = 1'b0;
                            st_nxt.intrq = 1'b1;
                            st_nxt.st    = ARCE_IDLE;
                        end else if (st_r.rem == 9'h001) begin
                            st_nxt.bsy   = 1'b0;
                            st_nxt.intrq = 1'b1;
                            st_nxt.st    = ARCE_IDLE;
                        end else begin
                            st_nxt.fa      = arce_step(st_r.fa, is_lba);
                            st_nxt.med_req = 1'b1;
                        end
                    end else if (st_r.sidx + 3'h1 < st_r.blk_n) begin
                        // Rest of the block is fetched even after a hard error
                        st_nxt.sidx    = st_r.sidx + 3'h1;
                        st_nxt.fa      = arce_step(st_r.fa, is_lba);
                        st_nxt.med_req = 1'b1;
                    end else begin
                        st_nxt.rptr  = 10'h000;
                        st_nxt.drq   = 1'b1;
                        st_nxt.bsy   = 1'b0;
                        st_nxt.intrq = 1'b1;
                        st_nxt.st    = ARCE_XFER;
                    end
                end
            end
            ARCE_XFER: begin
                if (rd_acc && idx == `ARCE_IDX_DATA) begin
                    st_nxt.rptr = st_r.rptr + 10'h001;
                    if (st_r.rptr == {st_r.blk_n[1:0] - 2'h1, `ARCE_SECT_LAST}) begin
                        st_nxt.drq = 1'b0;
                        if (st_r.rem == 9'h000 || st_r.hard) begin
                            st_nxt.st = ARCE_IDLE;
                        end else begin
                            st_nxt.bsy = 1'b1;
                            st_nxt.fa  = arce_step(st_r.fa, is_lba);
                            st_nxt.st  = ARCE_LOAD;
                        end
                    end
                end
            end
            default: begin
                st_nxt.st = ARCE_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read address restarts at zero for each block; the buffer never overruns its four sectors
    arce_sector_buf u_buf (
        .sys_clk (sys_clk),
        .we      (buf_we),
        .waddr   (buf_waddr),
        .wdata   (med_wdata),
        .raddr   (st_r.rptr),
        .rdata   (buf_rdata)
    );

    assign prdata     = st_r.prdata;
    assign pready     = st_r.pready;
    assign pslverr    = st_r.pslverr;
    assign intrq      = st_r.intrq;
    assign med_req    = st_r.med_req;
    assign med_addr   = st_r.fa;
    assign med_lba    = st_r.unit_hi[`ARCE_UNIT_LBA];
    assign med_verify = st_r.med_verify;

endmodule : arce_engine

// ---- test/arce_engine_properties.sv ----
/* Port-level properties of the read command engine.
   Assumes it is bound to arce_engine: one clock, async active-low reset. */
`timescale 1ns/1ps
`include "arce_consts.svh"
module arce_engine_chk (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        intrq,
    input wire logic        med_req,
    input wire logic [27:0] med_addr,
    input wire logic        med_lba,
    input wire logic        med_verify,
    input wire logic        med_wvalid,
    input wire logic [15:0] med_wdata,
    input wire logic        med_done,
    input wire logic [1:0]  med_status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic op_wr = psel && penable && pready && pwrite && paddr == 8'h1C;
    logic      mult_ok_r;
    // Block size legal only for 1, 2 or 4
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mult_ok_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 8'h20) begin
            mult_ok_r <= pwdata[2:0] inside {3'h1, 3'h2, 3'h4};
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    // Idle guess: no fetch and no pending interrupt
    sequence s_op(c);
        op_wr && pwdata[7:0] == c && !med_req && !intrq;
    endsequence
    AST_READ_START: assert property ((s_op(8'h20) or s_op(8'h21)) |-> ##2 (med_req && !med_verify))
        else $error("sector read did not start a fetch");
    AST_VERIFY_START: assert property ((s_op(8'h40) or s_op(8'h41)) |-> ##2 (med_req && med_verify))
        else $error("verify did not start a verify fetch");
    AST_MULTI_START: assert property (s_op(8'hC4) ##0 mult_ok_r |-> ##2 (med_req && !med_verify))
        else $error("block read did not start a fetch");
    AST_MULTI_ABORT: assert property (s_op(8'hC4) ##0 !mult_ok_r |-> !med_req [*3] ##0 intrq)
        else $error("block read without size not refused");
    AST_RECAL: assert property (op_wr && pwdata[7:4] == 4'h1 && !med_req |-> ##[1:3] (intrq && !med_req))
        else $error("no-operation did not complete");
    AST_REQ_STANDS: assert property (med_req && !med_done |=> med_req && $stable(med_addr))
        else $error("fetch request dropped or moved early");
    AST_IRQ_IDLE: assert property ($rose(intrq) |-> !med_req)
        else $error("interrupt raised in mid fetch");
    AST_STATUS_FORM: assert property (pready && !pwrite && paddr == 8'h1C |-> prdata[6] == !prdata[7] && prdata[4])
        else $error("status ready and busy disagree");
    AST_UNMAPPED: assert property (s_setup ##0 paddr[5:2] > 4'h8 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_ZERO_WAIT: assert property (s_setup |=> pready ##1 !pready)
        else $error("answer not in first access cycle");
endmodule : arce_engine_chk

bind arce_engine arce_engine_chk u_chk (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .intrq, .med_req, .med_addr, .med_lba, .med_verify, .med_wvalid, .med_wdata, .med_done,
    .med_status);

// ---- test/arce_media_model.sv ----
/* Media side model: answers each sector request with 256 words (none for verify) and a status.
   Assumes words {sector low byte, index}; status from the failing-address inputs. */
`timescale 1ns/1ps
`include "arce_consts.svh"
module arce_media_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        med_req,
    input  wire logic [27:0] med_addr,
    input  wire logic        med_verify,
    input  wire logic        slow,
    input  wire logic [27:0] bad_addr,
    input  wire logic [1:0]  bad_code,
    output logic             med_wvalid,
    output logic      [15:0] med_wdata,
    output logic             med_done,
    output logic      [1:0]  med_status
);
    logic [27:0] a;
    int          i;
    initial begin
        med_wvalid = 1'b0;
        med_wdata  = 16'h0000;
        med_done   = 1'b0;
        med_status = 2'h0;
        forever begin
            @(posedge sys_clk);
            if (med_done === 1'b1 || rst_b !== 1'b1 || med_req !== 1'b1) begin
                med_done   <= 1'b0;
                med_wvalid <= 1'b0;
                // Idle bus toggles so stale data never looks valid
                med_wdata  <= ~med_wdata;
            end else begin
                a = med_addr;
                for (i = 0; i < 256 && !med_verify; i++) begin
                    if (slow) begin
                        med_wvalid <= 1'b0;
                        @(posedge sys_clk);
                    end
                    med_wvalid <= 1'b1;
                    med_wdata  <= {a[7:0], 8'(i)};
                    @(posedge sys_clk);
                end
                med_wvalid <= 1'b0;
                med_done   <= 1'b1;
                med_status <= (a == bad_addr) ? bad_code : `ARCE_MED_OK;
            end
        end
    end
endmodule : arce_media_model

// ---- test/tb.sv ----
/* Self-checking bench: APB host tasks and an integer model of each command.
   Assumes arce_engine with zero-wait APB and the media model on its far side. */
`timescale 1ns/1ps
`include "arce_consts.svh"
module tb;
    logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, intrq;
    logic [7:0]  paddr, start_sec, unit_val;
    logic [31:0] pwdata, prdata, r;
    logic        med_req, med_lba, med_verify, med_wvalid, med_done, slow, e;
    logic [27:0] med_addr, bad_addr;
    logic [15:0] med_wdata;
    logic [1:0]  med_status, bad_code;
    int          n_mismatch, tests_run;
    arce_engine u_arce_engine (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .intrq, .med_req, .med_addr, .med_lba, .med_verify, .med_wvalid, .med_wdata, .med_done,
        .med_status);
    arce_media_model u_arce_media_model (.sys_clk, .rst_b, .med_req, .med_addr, .med_verify, .slow, .bad_addr,
        .bad_code, .med_wvalid, .med_wdata, .med_done, .med_status);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wrap_up();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t data got %h exp %h", $time, got, exp);
        end
    endtask : chk_data
    // One APB transfer; request held until pready is seen
    task automatic apb(input logic [3:0] i, input logic w, input logic [31:0] d, output logic [31:0] q,
                       output logic er);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= {2'h0, i, 2'h0};
        pwrite  <= w;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) n_mismatch++;
        q  = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        logic [31:0] q;
        logic        er;
        apb(i, 1'b1, {24'h0, d}, q, er);
    endtask : wr
    task automatic rd(input logic [3:0] i, output logic [31:0] q);
        logic er;
        apb(i, 1'b0, 32'h0, q, er);
    endtask : rd
    task automatic wait_irq();
        int t;
        t = 0;
        while (intrq !== 1'b1 && t < 4000) begin
            @(posedge sys_clk);
            t++;
        end
        chk_reg({31'h0, intrq}, 32'h1);
    endtask : wait_irq
    // Block read refused: error and aborted bits, interrupt, never busy
    task automatic chk_abort();
        logic [31:0] q;
        wr(`ARCE_IDX_OPCODE, `ARCE_OP_MULTI);
        wait_irq();
        rd(`ARCE_IDX_OPCODE, q);
        chk_reg(q & 32'hFB, 32'h51);
        rd(`ARCE_IDX_FEATURE, q);
        chk_reg(q & 32'hFF, 32'h04);
    endtask : chk_abort
    // Expected flow: blocks of min(blk, left), stop after a block with a hard fault
    task automatic do_cmd(input logic [7:0] op, input int cnt, input int blk, input int bad, input logic [1:0] code);
        int          n, k, b, j, fin;
        logic        hard, inb, vfy;
        logic [31:0] q;
        n = (cnt == 0) ? 256 : cnt;
        vfy = (op == `ARCE_OP_VERIFY0 || op == `ARCE_OP_VERIFY1);
        hard = 1'b0;
        k = 0;
        bad_addr <= (bad < 0) ? 28'hFFFFFFF : {20'h51234, 8'(start_sec + 8'(bad))};
        bad_code <= code;
        slow <= 1'($urandom);
        wr(`ARCE_IDX_COUNT, 8'(cnt));
        wr(`ARCE_IDX_SECTOR, start_sec);
        wr(`ARCE_IDX_TRK_LO, 8'h34);
        wr(`ARCE_IDX_TRK_HI, 8'h12);
        wr(`ARCE_IDX_UNIT, unit_val);
        wr(`ARCE_IDX_OPCODE, op);
        if (vfy) begin
            hard = (bad >= 0);
            wait_irq();
        end
        while (!vfy && k < n && !hard) begin
            b = (n - k < blk) ? n - k : blk;
            inb = (bad >= k && bad < k + b);
            hard = inb && code == `ARCE_MED_HARD;
            wait_irq();
            rd(`ARCE_IDX_OPCODE, q);
            // Corrected bit compared only in the block that holds a corrected fault, not a hard one
            chk_reg(q & ((inb && !hard) ? 32'hFF : 32'hFB), {24'h0, 7'h2C, hard} | ((inb && !hard) ? 32'h4 : 32'h0));
            for (j = 0; j < b * 256; j++) begin
                rd(`ARCE_IDX_DATA, q);
                chk_data(q[15:0], {8'(start_sec + 8'(k + j / 256)), 8'(j)});
            end
            k += b;
        end
        fin = hard ? bad : n - 1;
        rd(`ARCE_IDX_OPCODE, q);
        chk_reg(q & 32'hFB, {31'h28, hard});
        rd(`ARCE_IDX_SECTOR, q);
        chk_reg(q & 32'hFF, {24'h0, 8'(start_sec + 8'(fin))});
        if (hard) begin
            rd(`ARCE_IDX_FEATURE, q);
            chk_reg(q & 32'hFF, 32'h40);
        end
        if (hard && vfy) begin
            rd(`ARCE_IDX_COUNT, q);
            chk_reg(q & 32'hFF, 32'(n - bad));
        end
        if (!hard) chk_reg({3'h0, med_lba, med_addr}, {3'h0, unit_val[6], 20'h51234, 8'(start_sec + 8'(fin))});
    endtask : do_cmd
    initial begin
        #800000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, slow, bad_code} = '0;
        bad_addr = 28'hFFFFFFF;
        unit_val = 8'hE5;
        rst_b = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        r = $urandom(32'h786981f9);
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(`ARCE_IDX_OPCODE, r);
        chk_reg(r, 32'h50);
        apb(4'h9, 1'b0, 32'h0, r, e);
        chk_reg({r[30:0], e}, 32'h1);
        start_sec = 8'($urandom) & 8'h7F;
        do_cmd(`ARCE_OP_READ0, 2, 1, -1, `ARCE_MED_OK);
        do_cmd(`ARCE_OP_READ1, 3, 1, 1, `ARCE_MED_HARD);
        chk_abort();
        wr(`ARCE_IDX_MULT, 8'h02);
        do_cmd(`ARCE_OP_MULTI, 3, 2, 1, `ARCE_MED_CORR);
        do_cmd(`ARCE_OP_MULTI, 4, 2, 0, `ARCE_MED_HARD);
        wr(`ARCE_IDX_MULT, 8'h01);
        do_cmd(`ARCE_OP_MULTI, 2, 1, -1, `ARCE_MED_OK);
        wr(`ARCE_IDX_MULT, 8'h04);
        do_cmd(`ARCE_OP_MULTI, 5, 4, 2, `ARCE_MED_CORR);
        // Unsupported size disables block reads again
        wr(`ARCE_IDX_MULT, 8'h03);
        chk_abort();
        do_cmd(`ARCE_OP_VERIFY1, 3, 1, 1, `ARCE_MED_HARD);
        // Track form: start low enough that no sector roll occurs
        unit_val = 8'hA5;
        start_sec = (8'($urandom) & 8'h0F) | 8'h01;
        do_cmd(`ARCE_OP_READ1, 3, 1, -1, `ARCE_MED_OK);
        unit_val = 8'hE5;
        start_sec = 8'h00;
        do_cmd(`ARCE_OP_VERIFY0, 0, 1, -1, `ARCE_MED_OK);
        wr(`ARCE_IDX_OPCODE, {`ARCE_OP_RECAL_HI, 4'($urandom)});
        wait_irq();
        rd(`ARCE_IDX_OPCODE, r);
        chk_reg(r & 32'hFF, 32'h50);
        wrap_up();
    end
endmodule : tb
